// ### pkg/tnco_pkg.sv
// package for the timing oscillator and timing error detector
// assumes one processing clock and a control-word style host port
// What this block does
// - timing oscillator is a bare phase accumulator, no sine or cosine stage.
// - each output sample gets an oscillator pulse plus accumulator phase.
// - control bit 5 lets the external sync input reset the accumulator.
// - control bits 3-4 pick the serial offset-frequency word width.
// - control bit 2 adds offset to centre frequency, else centre alone.
// - control bit 1 holds the phase accumulator cleared.
// - control bit 0 makes a frequency update also load the accumulator.
// - a dedicated word holds the centre frequency, the step per clock.
// - bits 0-7 of the phase word give an 8-bit phase offset.
// - writing a strobe word transfers pending frequency or phase values.
// - error detector compares oscillator-carry and reference-edge counters.
// - bits 16-27 of the divider word preload the oscillator-side counter.
// - bits 0-11 of the divider word preload the reference-side counter.
// - the 16-bit timing error goes out serially and is host readable.
// - resampler modes take 0, 6, 13, 23, 7 or 17 clocks per input.
// - with the polyphase filter, output rate follows oscillator pulses.
package tnco_pkg;
  localparam logic [7:0] CW_CONTROL = 8'h0b;
  localparam logic [7:0] CW_CENTER = 8'h0c;
  localparam logic [7:0] CW_PHASE = 8'h0d;
  localparam logic [7:0] CW_FREQ_STROBE = 8'h0e;
  localparam logic [7:0] CW_PHASE_STROBE = 8'h0f;
  localparam logic [7:0] CW_DIVIDERS = 8'h12;
  localparam logic [7:0] RD_TIMING_ERROR = 8'h40;
  localparam int CTL_LOAD_BIT = 0;
  localparam int CTL_CLEAR_BIT = 1;
  localparam int CTL_OFS_EN_BIT = 2;
  localparam int CTL_WIDTH_LSB = 3;
  localparam int CTL_SYNC_BIT = 5;
  localparam int PHASE_LSB = 0;
  localparam int REF_DIV_LSB = 0;
  localparam int OSC_DIV_LSB = 16;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [5:0] CYC_BYPASS = 6'h00;
  localparam logic [5:0] CYC_POLY = 6'h06;
  localparam logic [5:0] CYC_POLY_HB1 = 6'h0d;
  localparam logic [5:0] CYC_POLY_HB2 = 6'h17;
  localparam logic [5:0] CYC_HB1 = 6'h07;
  localparam logic [5:0] CYC_HB2 = 6'h11;
  localparam int SER_BITS = 16;
  typedef enum logic [2:0] {
    MODE_BYPASS = 3'h0, MODE_POLY = 3'h1, MODE_POLY_HB1 = 3'h2,
    MODE_POLY_HB2 = 3'h3, MODE_HB1 = 3'h4, MODE_HB2 = 3'h5
  } tnco_mode_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} tnco_state_t;
endpackage

// ### verilog/tnco_top.sv
// timing oscillator, timing error detector and resampler clock budget
// assumes the reference, sync and serial offset pins are asynchronous
module tnco_top #(
  parameter int ACC_W = 32,
  parameter int DIV_W = 12
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] cw_addr,
  input wire logic [31:0] cw_wdata,
  input wire logic cw_wr,
  input wire logic [7:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic timing_reference_clock_input,
  input wire logic ext_sync_in,
  input wire logic ofs_ser_clk,
  input wire logic ofs_ser_data,
  input wire logic ofs_ser_load,
  input wire logic [2:0] resamp_mode,
  input wire logic resamp_in_strobe,
  output logic resamp_busy,
  output logic resamp_out_strobe,
  output logic sample_pulse,
  output logic [31:0] sample_phase,
  output logic [15:0] symbol_timing_error,
  output logic te_ser_data,
  output logic te_ser_frame
);
  import tnco_pkg::*;

  // only the documented widths are served
  if (ACC_W != 32) $error("accumulator width must be 32");
  if (DIV_W != 12) $error("divider width must be 12");

  // reset release
  logic rst_s1_reg, rst_s2_reg;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  wire rst_n = rst_s2_reg;

  // pin synchronisers, third stage only for edges
  logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg;
  wire [3:0] pins = {ofs_ser_load, ofs_ser_clk, ext_sync_in, timing_reference_clock_input};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
    end else if (clk_en) begin
      pin_s1_reg <= pins;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end
  logic ser_dat_s1_reg, ser_dat_s2_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_dat_s1_reg <= 1'b0;
      ser_dat_s2_reg <= 1'b0;
    end else if (clk_en) begin
      ser_dat_s1_reg <= ofs_ser_data;
      ser_dat_s2_reg <= ser_dat_s1_reg;
    end
  end
  wire [3:0] pin_rise = pin_s2_reg & ~pin_s3_reg;
  wire ref_edge = pin_rise[0];
  wire sync_edge = pin_rise[1];
  wire ser_clk_edge = pin_rise[2];
  wire ser_load_edge = pin_rise[3];

  // control words
  logic [31:0] ctl_reg, center_reg, phase_word_reg, div_reg;
  wire wr_ctl = cw_wr && cw_addr == CW_CONTROL;
  wire wr_center = cw_wr && cw_addr == CW_CENTER;
  wire wr_phase = cw_wr && cw_addr == CW_PHASE;
  wire freq_strobe = cw_wr && cw_addr == CW_FREQ_STROBE;
  wire phase_strobe = cw_wr && cw_addr == CW_PHASE_STROBE;
  wire wr_div = cw_wr && cw_addr == CW_DIVIDERS;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= CTL_RESET;
      center_reg <= WORD_RESET;
      phase_word_reg <= WORD_RESET;
      div_reg <= WORD_RESET;
    end else if (clk_en) begin
      if (wr_ctl) ctl_reg <= cw_wdata;
      if (wr_center) center_reg <= cw_wdata;
      if (wr_phase) phase_word_reg <= cw_wdata;
      if (wr_div) div_reg <= cw_wdata;
    end
  end
  wire load_on_update = ctl_reg[CTL_LOAD_BIT];
  wire acc_clear = ctl_reg[CTL_CLEAR_BIT];
  wire ofs_enable = ctl_reg[CTL_OFS_EN_BIT];
  wire [1:0] ofs_width_sel = ctl_reg[CTL_WIDTH_LSB +: 2];
  wire sync_enable = ctl_reg[CTL_SYNC_BIT];
  wire [7:0] phase_pending = phase_word_reg[PHASE_LSB +: 8];
  wire [DIV_W-1:0] osc_div_preload = div_reg[OSC_DIV_LSB +: DIV_W];
  wire [DIV_W-1:0] ref_div_preload = div_reg[REF_DIV_LSB +: DIV_W];

  // serial offset word, left aligned by selected width
  logic [31:0] ofs_shift_reg, ofs_pending_reg;
  wire [4:0] ofs_pad = 5'(6'd24 - {1'b0, ofs_width_sel, 3'b000});
  wire [31:0] ofs_aligned = ofs_shift_reg << ofs_pad;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_shift_reg <= WORD_RESET;
      ofs_pending_reg <= WORD_RESET;
    end else if (clk_en) begin
      if (ser_clk_edge) ofs_shift_reg <= {ofs_shift_reg[30:0], ser_dat_s2_reg};
      if (ser_load_edge) ofs_pending_reg <= ofs_aligned;
    end
  end

  // active frequency and phase, moved in by strobes
  logic [31:0] step_reg;
  logic [7:0] phase_off_reg;
  wire [31:0] step_next = ofs_enable ? center_reg + ofs_pending_reg : center_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_reg <= WORD_RESET;
      phase_off_reg <= 8'h00;
    end else if (clk_en) begin
      if (freq_strobe) step_reg <= step_next;
      if (phase_strobe) phase_off_reg <= phase_pending;
    end
  end

  // phase accumulator, no lookup stage
  logic [31:0] acc_reg;
  wire [32:0] acc_sum = {1'b0, acc_reg} + {1'b0, step_reg};
  wire sync_hit = sync_enable && sync_edge;
  wire osc_carry = acc_sum[32] && !acc_clear && !sync_hit;
  logic [31:0] acc_next;
  always_comb begin
    if (acc_clear || sync_hit) acc_next = 32'h0000_0000;
    else if (freq_strobe && load_on_update) acc_next = step_next;
    else acc_next = acc_sum[31:0];
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) acc_reg <= WORD_RESET;
    else if (clk_en) acc_reg <= acc_next;
  end

  // sample pulse and phase towards the resampler
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_pulse <= 1'b0;
      sample_phase <= WORD_RESET;
    end else if (clk_en) begin
      sample_pulse <= osc_carry;
      sample_phase <= acc_reg + {phase_off_reg, 24'h00_0000};
    end
  end

  // divider counters and error capture
  logic [DIV_W-1:0] osc_cnt_reg, ref_cnt_reg;
  wire osc_tc = osc_cnt_reg == '0;
  wire ref_tc = ref_cnt_reg == '0;
  wire [DIV_W-1:0] osc_cnt_dec = osc_cnt_reg - DIV_W'(1);
  wire [DIV_W-1:0] ref_cnt_dec = ref_cnt_reg - DIV_W'(1);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_reg <= '0;
      ref_cnt_reg <= '0;
      symbol_timing_error <= 16'h0000;
    end else if (clk_en) begin
      if (osc_carry) osc_cnt_reg <= osc_tc ? osc_div_preload : osc_cnt_dec;
      if (ref_edge) begin
        ref_cnt_reg <= ref_tc ? ref_div_preload : ref_cnt_dec;
        if (ref_tc) symbol_timing_error <= {4'h0, osc_cnt_reg};
      end
    end
  end
  wire te_capture = ref_edge && ref_tc;

  // serial error output, msb first, frame high during the word
  logic [15:0] te_shift_reg;
  logic [4:0] te_bits_reg;
  logic te_load_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      te_load_reg <= 1'b0;
      te_shift_reg <= 16'h0000;
      te_bits_reg <= 5'h00;
      te_ser_data <= 1'b0;
      te_ser_frame <= 1'b0;
    end else if (clk_en) begin
      te_load_reg <= te_capture;
      if (te_load_reg) begin
        te_shift_reg <= {symbol_timing_error[14:0], 1'b0};
        te_ser_data <= symbol_timing_error[15];
        te_ser_frame <= 1'b1;
        te_bits_reg <= 5'(SER_BITS - 1);
      end else if (te_bits_reg != 5'h00) begin
        te_shift_reg <= {te_shift_reg[14:0], 1'b0};
        te_ser_data <= te_shift_reg[15];
        te_bits_reg <= te_bits_reg - 5'h01;
      end else begin
        te_ser_frame <= 1'b0;
        te_ser_data <= 1'b0;
      end
    end
  end

  // host readback
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_addr)
      CW_CONTROL: rd_mux = ctl_reg;
      CW_CENTER: rd_mux = center_reg;
      CW_PHASE: rd_mux = phase_word_reg;
      CW_DIVIDERS: rd_mux = div_reg;
      RD_TIMING_ERROR: rd_mux = {16'h0000, symbol_timing_error};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rd_data <= WORD_RESET;
    else if (clk_en) rd_data <= rd_mux;
  end

  // resampler clock budget per input sample
  tnco_mode_t mode;
  assign mode = tnco_mode_t'(resamp_mode);
  logic [5:0] budget;
  always_comb begin
    unique case (mode)
      MODE_POLY: budget = CYC_POLY;
      MODE_POLY_HB1: budget = CYC_POLY_HB1;
      MODE_POLY_HB2: budget = CYC_POLY_HB2;
      MODE_HB1: budget = CYC_HB1;
      MODE_HB2: budget = CYC_HB2;
      default: budget = CYC_BYPASS;
    endcase
  end
  wire poly_used = mode == MODE_POLY || mode == MODE_POLY_HB1 || mode == MODE_POLY_HB2;
  tnco_state_t state_reg, state_next;
  logic [5:0] cyc_reg, cyc_next;
  logic done;
  always_comb begin
    state_next = state_reg;
    cyc_next = cyc_reg;
    done = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (resamp_in_strobe) begin
          if (budget == CYC_BYPASS) done = 1'b1;
          else begin
            state_next = ST_BUSY;
            cyc_next = 6'(budget - 6'h01);
          end
        end
      end
      ST_BUSY: begin
        if (cyc_reg == 6'h01) begin
          state_next = ST_IDLE;
          done = 1'b1;
        end
        cyc_next = 6'(cyc_reg - 6'h01);
      end
      default: state_next = ST_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 6'h00;
    end else if (clk_en) begin
      state_reg <= state_next;
      cyc_reg <= cyc_next;
    end
  end
  assign resamp_busy = state_reg == ST_BUSY;
  assign resamp_out_strobe = clk_en && (poly_used ? osc_carry : done);

  // checks
  a_clear_holds_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && acc_clear |=> acc_reg == 32'h0000_0000) else $error("clear not applied");
  a_sync_clears_acc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && sync_enable && sync_edge |=> acc_reg == 32'h0000_0000)
    else $error("sync did not clear");
  a_load_on_update: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && freq_strobe && load_on_update && !acc_clear && !sync_hit
    |=> acc_reg == step_reg) else $error("update did not load accumulator");
  a_offset_gating: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && freq_strobe && !ofs_enable |=> step_reg == $past(center_reg))
    else $error("offset added while disabled");
  a_phase_strobe_moves: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && phase_strobe |=> phase_off_reg == $past(phase_word_reg[7:0]))
    else $error("phase strobe ignored");
  a_pulse_follows_carry: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en |=> sample_pulse == $past(osc_carry)) else $error("pulse lost");
  a_error_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && te_capture |=> symbol_timing_error == {4'h0, $past(osc_cnt_reg)})
    else $error("error not captured");
  a_osc_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && osc_carry && osc_tc |=> osc_cnt_reg == $past(osc_div_preload))
    else $error("oscillator counter not reloaded");
  a_ref_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && te_capture |=> ref_cnt_reg == $past(ref_div_preload))
    else $error("reference counter not reloaded");
  sequence s_frame_start;
    clk_en && te_load_reg;
  endsequence
  a_serial_msb_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_frame_start |=> te_ser_frame && te_ser_data == symbol_timing_error[15])
    else $error("serial word start wrong");
  sequence s_poly_start;
    clk_en && state_reg == ST_IDLE && resamp_in_strobe && mode == MODE_POLY;
  endsequence
  a_poly_budget: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_poly_start
    ##1 clk_en [*5] |=> state_reg == ST_IDLE) else $error("polyphase budget wrong");
  a_poly_rate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    poly_used && resamp_out_strobe |=> sample_pulse) else $error("output not oscillator paced");
  a_freeze_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !clk_en |=> acc_reg == $past(acc_reg) && sample_phase == $past(sample_phase))
    else $error("state moved while frozen");
  a_osc_count_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && osc_carry && !osc_tc |=> osc_cnt_reg == $past(osc_cnt_reg) - DIV_W'(1))
    else $error("oscillator counter did not step");
  a_ref_count_down: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && ref_edge && !ref_tc |=> ref_cnt_reg == $past(ref_cnt_reg) - DIV_W'(1))
    else $error("reference counter did not step");
  a_error_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(clk_en && te_capture) |=> $stable(symbol_timing_error))
    else $error("error changed without capture");
  a_serial_lsb_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && !te_load_reg && !te_capture && te_bits_reg == 5'h01
    |=> te_ser_frame && te_ser_data == symbol_timing_error[0]) else $error("serial word end wrong");
  a_bypass_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_reg == ST_IDLE && resamp_in_strobe && budget == CYC_BYPASS
    |-> resamp_out_strobe) else $error("bypass sample not passed");
  a_busy_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clk_en && state_reg == ST_BUSY && cyc_reg != 6'h01 |=> state_reg == ST_BUSY)
    else $error("busy period cut short");
endmodule

// ### sim/tnco_far_end.sv
// far-side model: reference clock, sync pin and serial offset-word pins
// assumes its tasks are called by the bench just after a falling edge
module tnco_far_end (
  input wire logic ref_clk,
  output logic timing_reference_clock_input,
  output logic ext_sync_in,
  output logic ofs_ser_clk,
  output logic ofs_ser_data,
  output logic ofs_ser_load
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    timing_reference_clock_input = 1'b0;
    ext_sync_in = 1'b0;
    ofs_ser_clk = 1'b0;
    ofs_ser_data = 1'b1;
    ofs_ser_load = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic ref_edges(input int n);
    repeat (n) begin
      timing_reference_clock_input = 1'b1;
      wait_n(4);
      timing_reference_clock_input = 1'b0;
      wait_n(4);
    end
  endtask
  task automatic sync_edge();
    ext_sync_in = 1'b1;
    wait_n(4);
    ext_sync_in = 1'b0;
    wait_n(4);
  endtask
  // msb first, serial clock idle low between words
  task automatic ser_send(input logic [31:0] w, input int n);
    for (int i = 31; i > 31 - n; i--) begin
      ofs_ser_data = w[i];
      wait_n(3);
      ofs_ser_clk = 1'b1;
      wait_n(3);
      ofs_ser_clk = 1'b0;
    end
    ofs_ser_load = 1'b1;
    wait_n(4);
    ofs_ser_load = 1'b0;
    ofs_ser_data = ~ofs_ser_data;
    wait_n(4);
  endtask
endmodule

// ### sim/tnco_top_tb.sv
// bench for the timing oscillator and timing error detector
// assumes the far-side model drives the pins and clk_en runs free except for one 10-cycle freeze
module tnco_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tnco_pkg::*;
  logic ref_clk, rstn, clk_en, cw_wr, resamp_in_strobe;
  logic resamp_busy, resamp_out_strobe, sample_pulse, te_ser_data, te_ser_frame;
  logic timing_reference_clock_input, ext_sync_in, ofs_ser_clk, ofs_ser_data, ofs_ser_load;
  logic [7:0] cw_addr, rd_addr;
  logic [31:0] cw_wdata, rd_data, sample_phase, ph;
  logic [2:0] resamp_mode;
  logic [15:0] symbol_timing_error, ser_word, e1, e2;
  int error_cnt, checked, pulse_cnt, ostb_cnt, p, o, p0, b;
  int budget[8] = '{0, 6, 13, 23, 7, 17, 0, 0};
  logic [7:0] regs[4] = '{CW_CONTROL, CW_CENTER, CW_PHASE, CW_DIVIDERS};
  tnco_top u_dut (.ref_clk, .rstn, .clk_en, .cw_addr, .cw_wdata, .cw_wr, .rd_addr,
    .rd_data, .timing_reference_clock_input, .ext_sync_in, .ofs_ser_clk, .ofs_ser_data,
    .ofs_ser_load, .resamp_mode, .resamp_in_strobe, .resamp_busy, .resamp_out_strobe,
    .sample_pulse, .sample_phase, .symbol_timing_error, .te_ser_data, .te_ser_frame);
  tnco_far_end u_far (.ref_clk, .timing_reference_clock_input, .ext_sync_in, .ofs_ser_clk,
    .ofs_ser_data, .ofs_ser_load);
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (sample_pulse === 1'b1) pulse_cnt++;
    if (resamp_out_strobe === 1'b1) ostb_cnt++;
    if (te_ser_frame === 1'b1) ser_word <= {ser_word[14:0], te_ser_data};
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    cw_addr = a;
    cw_wdata = d;
    cw_wr = 1'b1;
    @(negedge ref_clk);
    cw_wr = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    @(negedge ref_clk);
    rd_addr = a;
    @(negedge ref_clk);
    chk(rd_data, exp);
  endtask
  task automatic set_freq(input logic [31:0] f, input logic [31:0] ctl);
    wr(CW_CONTROL, ctl);
    wr(CW_CENTER, f);
    wr(CW_FREQ_STROBE, 32'h0);
  endtask
  // pulses and resampler strobes seen over n cycles
  task automatic span(input int n, output int pc, output int oc);
    pc = pulse_cnt;
    oc = ostb_cnt;
    cyc(n);
    pc = pulse_cnt - pc;
    oc = ostb_cnt - oc;
  endtask
  // oscillator-side counter after k carries from zero, preload 10
  function automatic logic [15:0] te_of(input int k);
    te_of = (k % 11 == 0) ? 16'h0 : 16'(11 - k % 11);
  endfunction
  task automatic tend(input string s);
    $display("test %0s done", s);
  endtask
  task automatic wrap_up();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    rstn = 1'b0;
    cw_wr = 1'b0;
    cw_addr = 8'h00;
    cw_wdata = 32'h0;
    rd_addr = 8'h00;
    resamp_mode = 3'h0;
    resamp_in_strobe = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    cyc(4);
    foreach (regs[i]) chk_rd(regs[i], 32'h0);
    foreach (regs[i]) wr(regs[i], 32'ha5c3_0000 | 32'(regs[i]));
    wr(8'h20, 32'hffff_ffff);
    foreach (regs[i]) chk_rd(regs[i], 32'ha5c3_0000 | 32'(regs[i]));
    chk_rd(8'h20, 32'h0);
    chk_rd(CW_FREQ_STROBE, 32'h0);
    wr(CW_DIVIDERS, 32'h0);
    tend("registers");
    wr(CW_PHASE, 32'h55);
    wr(CW_PHASE_STROBE, 32'h0);
    set_freq(32'h4000_0000, 32'h2);
    cyc(6);
    chk(sample_phase, 32'h5500_0000);
    span(20, p, o);
    chk(p, 0);
    wr(CW_CONTROL, 32'h0);
    resamp_mode = MODE_POLY;
    cyc(4);
    span(40, p, o);
    chk(p, 10);
    chk(o, 10);
    @(negedge ref_clk);
    clk_en = 1'b0;
    ph = sample_phase;
    span(10, p, o);
    chk(sample_phase, ph);
    chk(o, 0);
    clk_en = 1'b1;
    tend("oscillator");
    for (int k = 0; k < 4; k++) begin
      set_freq(32'h4000_0000, 32'(k << 3) | 32'h2);
      u_far.ser_send(32'h4000_0000, 8 * (k + 1));
      set_freq(32'h4000_0000, 32'(k << 3) | 32'h4);
      cyc(6);
      span(40, p, o);
      chk(p, 20);
    end
    set_freq(32'h4000_0000, 32'h0);
    cyc(6);
    span(40, p, o);
    chk(p, 10);
    tend("offset");
    set_freq(32'h0010_0000, 32'h2);
    wr(CW_CONTROL, 32'h0);
    cyc(20);
    set_freq(32'h1, 32'h1);
    cyc(2);
    chk((sample_phase - 32'h5500_0000) < 16, 1);
    wr(CW_CONTROL, 32'h0);
    cyc(40);
    u_far.sync_edge();
    chk((sample_phase - 32'h5500_0000) > 40, 1);
    wr(CW_CONTROL, 32'h20);
    u_far.sync_edge();
    chk((sample_phase - 32'h5500_0000) < 16, 1);
    tend("load and sync");
    set_freq(32'h4000_0000, 32'h2);
    wr(CW_DIVIDERS, 32'h000a_0002);
    p0 = pulse_cnt;
    wr(CW_CONTROL, 32'h0);
    cyc(30);
    wr(CW_CONTROL, 32'h2);
    cyc(6);
    e1 = te_of(pulse_cnt - p0);
    u_far.ref_edges(1);
    cyc(30);
    chk(symbol_timing_error, e1);
    chk(ser_word, e1);
    chk_rd(RD_TIMING_ERROR, {16'h0, e1});
    wr(CW_CONTROL, 32'h0);
    cyc(13);
    wr(CW_CONTROL, 32'h2);
    cyc(6);
    e2 = te_of(pulse_cnt - p0);
    u_far.ref_edges(2);
    cyc(6);
    chk(symbol_timing_error, e1);
    u_far.ref_edges(1);
    cyc(6);
    chk(symbol_timing_error, e2);
    tend("timing error");
    for (int m = 0; m < 8; m++) begin
      o = ostb_cnt;
      @(negedge ref_clk);
      resamp_mode = 3'(m);
      @(negedge ref_clk);
      resamp_in_strobe = 1'b1;
      @(negedge ref_clk);
      resamp_in_strobe = 1'b0;
      b = 0;
      while (resamp_busy === 1'b1 && b < 40) begin
        b++;
        @(negedge ref_clk);
      end
      chk(b, budget[m] == 0 ? 0 : budget[m] - 1);
      chk(ostb_cnt - o, (m >= 1 && m <= 3) ? 0 : 1);
    end
    tend("resampler");
    wrap_up();
  end
endmodule
